// ===== include/sdram_pkg.sv
// constants, command decode and column sequencing shared by the burst access logic
package sdram_pkg;
	localparam int          COL_W      = 8;     // column address bits
	localparam int          DQ_W       = 16;    // data bus width
	localparam int          MODE_W     = 12;    // mode register width
	localparam int          ROW_W_DOC  = 11;    // row address bits
	localparam int          PIPE_DEPTH = 3;     // read pipe covers the longest latency
	// mode register field positions
	localparam int          BL_LSB     = 0;
	localparam int          BT_BIT     = 3;
	localparam int          LAT_LSB    = 4;
	localparam int          WM_LSB     = 9;
	// address line roles during commands
	localparam int          A_AP       = 10;
	localparam int          A_BANK     = 11;
	// field encodings
	localparam logic [2:0]  BL_1       = 3'h0;
	localparam logic [2:0]  BL_2       = 3'h1;
	localparam logic [2:0]  BL_4       = 3'h2;
	localparam logic [2:0]  BL_8       = 3'h3;
	localparam logic [2:0]  BL_FULL    = 3'h7;
	localparam logic [2:0]  LAT_2      = 3'h2;
	localparam logic [2:0]  LAT_3      = 3'h3;
	localparam logic [2:0]  WM_BURST   = 3'h0;
	localparam logic [2:0]  WM_SINGLE  = 3'h1;
	// value held before the first mode load: length one, sequential, latency two
	localparam logic [11:0] MODE_RESET = 12'h020;
	// byte mask latencies in cycles
	localparam int          READ_MASK_DELAY  = 2;
	localparam int          WRITE_MASK_DELAY = 0;

	typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE,
		CMD_PRE, CMD_BST, CMD_MRS, CMD_REF} cmd_e;

	// command from the four strobes; deselect reads as no operation
	function automatic cmd_e decode_cmd(input logic cs_n, input logic ras_n,
			input logic cas_n, input logic we_n);
		if (cs_n)
			return CMD_NOP;
		case ({ras_n, cas_n, we_n})
			3'h0:    return CMD_MRS;
			3'h1:    return CMD_REF;
			3'h2:    return CMD_PRE;
			3'h3:    return CMD_ACT;
			3'h4:    return CMD_WRITE;
			3'h5:    return CMD_READ;
			3'h6:    return CMD_BST;
			default: return CMD_NOP;
		endcase
	endfunction : decode_cmd

	// wrap mask of the burst block; reserved codes behave as length one
	function automatic logic [COL_W-1:0] burst_mask(input logic [2:0] bl);
		case (bl)
			BL_2:    return 8'h01;
			BL_4:    return 8'h03;
			BL_8:    return 8'h07;
			BL_FULL: return 8'hff;
			default: return 8'h00;
		endcase
	endfunction : burst_mask

	// column of transfer cnt: add or xor inside the aligned block
	function automatic logic [COL_W-1:0] col_at(input logic [COL_W-1:0] start,
			input logic [COL_W-1:0] cnt, input logic [COL_W-1:0] mask, input logic ilv);
		logic [COL_W-1:0] low;
		low = ilv ? (start ^ cnt) : COL_W'(start + cnt);
		return (start & ~mask) | (low & mask);
	endfunction : col_at
endpackage : sdram_pkg

// ===== include/sdram_ifs.sv
// carriers between the core, its burst sequencer and its cell array
`timescale 1ns/100ps
`default_nettype none
interface burst_if;
	logic       start;   // read or write command this cycle
	logic       stop;    // burst stop or precharge of the burst bank
	logic       single;  // write with single write mode
	logic       ap_in;   // auto-precharge requested
	logic       bank_in; // bank of the command
	logic [7:0] col_in;  // start column
	logic [2:0] bl;      // burst length field
	logic       ilv;     // interleaved order
	logic       valid;   // a transfer happens this cycle
	logic       last;    // final transfer of a fixed burst
	logic       ap;      // burst ends in auto-precharge
	logic       bank;    // bank of the transfer
	logic [7:0] col;     // column of the transfer
	modport ctl(output start, stop, single, ap_in, bank_in, col_in, bl, ilv,
		input valid, last, ap, bank, col);
	modport seq(input start, stop, single, ap_in, bank_in, col_in, bl, ilv,
		output valid, last, ap, bank, col);
endinterface : burst_if

interface store_if #(parameter int ROW_W = 11);
	logic [1:0]       we;    // byte write enables, bit 1 upper
	logic             bank;
	logic [ROW_W-1:0] row;
	logic [7:0]       col;
	logic [15:0]      wdata;
	logic [15:0]      rdata;
	modport ctl(output we, bank, row, col, wdata, input rdata);
	modport mem(input we, bank, row, col, wdata, output rdata);
endinterface : store_if
`default_nettype wire

// ===== src/burst_seq.sv
// burst counter producing one column per cycle in sequential or interleaved order
`timescale 1ns/100ps
`default_nettype none
module burst_seq
	import sdram_pkg::*;
(
	input  wire logic I_MCLK, // clock
	input  wire logic I_RST,  // async reset, high
	input  wire logic I_CKE,  // low freezes the burst
	burst_if.seq      b       // burst control
);
	typedef struct packed {
		logic             run;
		logic [COL_W-1:0] start;
		logic [COL_W-1:0] cnt;
		logic             bank;
		logic             ap;
		logic             single;
	} seq_s;
	seq_s             s_q, s_d;
	logic [COL_W-1:0] mask;
	logic             full;

	// transfer of this cycle and next counter state
	always_comb begin
		full   = b.bl == BL_FULL;
		mask   = (b.start ? b.single : s_q.single) ? '0 : burst_mask(b.bl);
		s_d    = s_q;
		b.valid = 1'b0;
		b.last  = 1'b0;
		b.ap    = s_q.ap;
		b.bank  = s_q.bank;
		b.col   = col_at(s_q.start, s_q.cnt, mask, b.ilv & ~full);
		if (b.start) begin
			b.valid    = 1'b1;                    // first word in the command cycle
			b.col      = b.col_in;
			b.bank     = b.bank_in;
			b.ap       = b.ap_in & ~full;
			b.last     = mask == '0;
			s_d.run    = mask != '0;
			s_d.start  = b.col_in;
			s_d.cnt    = 8'h01;
			s_d.bank   = b.bank_in;
			s_d.ap     = b.ap_in & ~full;
			s_d.single = b.single;
		end else if (s_q.run && b.stop) begin
			s_d.run = 1'b0;                       // stop takes effect in its own cycle
		end else if (s_q.run) begin
			b.valid = 1'b1;
			b.last  = !full && s_q.cnt == mask;    // full page never ends alone
			s_d.cnt = COL_W'(s_q.cnt + 8'h01);     // wraps after 256 in full page
			s_d.run = !b.last;
		end
		if (!I_CKE)
			s_d = s_q;
	end

	// state register
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	property p_seq_step;
		@(posedge I_MCLK) disable iff (I_RST || !I_CKE)
		b.valid && !b.start && !b.ilv && b.bl == BL_4 && !s_q.single
		|-> b.col[1:0] == 2'(s_q.start[1:0] + s_q.cnt[1:0]) && b.col[7:2] == s_q.start[7:2];
	endproperty
	a_seq_step: assert property (p_seq_step) else $error("sequential column wrong");
endmodule : burst_seq
`default_nettype wire

// ===== src/sdram_store.sv
// cell array of both banks with per-byte write enables
`timescale 1ns/100ps
`default_nettype none
module sdram_store #(
	parameter int ROW_W = 11 // row address bits
) (
	input  wire logic I_MCLK, // clock
	store_if.mem      m       // array access
);
	localparam int DEPTH = 2 ** (ROW_W + 9);
	logic [15:0] cells [DEPTH];
	logic [ROW_W+8:0] idx;

	// contents are not reset, as in a real array
	assign idx     = {m.bank, m.row, m.col};
	assign m.rdata = cells[idx];

	// each byte lane written on its own enable; one process keeps the array single-writer
	always_ff @(posedge I_MCLK) begin
		for (int g = 0; g < 2; g++) begin
			if (m.we[g])
				cells[idx][g*8 +: 8] <= m.wdata[g*8 +: 8];
		end
	end
endmodule : sdram_store
`default_nettype wire

// ===== src/sdram_burst_core.sv
// burst read and write datapath of a two bank 16-bit synchronous dram
// What this block does
// - write mode 000 makes writes follow the programmed burst length
// - write mode 001 writes only the addressed column per write command
// - burst write starts in the write command cycle at its column and bank
// - full page covers 256 columns sequentially, wrapping until stopped
// - mode bit 3 picks sequential (0) or interleaved (1) order
// - mode bits 6..4: 010 is two clocks latency, 011 three; others reserved
// - sequential adds, interleaved xors, within the aligned burst block
// - precharge with line 10 low hits one bank, high hits both
// - line 11 picks bank 0 or 1 for every bank command
// - column on lines 0..7, lines 8..9 ignored, line 10 auto-precharge
// - first read word after latency, then one word per clock
// - drivers on at latency minus one, off after last word except full page
// - read byte masks blank their byte two clocks later
// - write data taken with the command and then each clock
// - burst write ends by itself; full page needs burst stop
// - write byte masks block their byte in the same clock
// - read auto-precharge starts one or two clocks before last word
// - auto-precharge ignored in full page mode
// - mode load command copies address lines 0..11 into the mode register
`timescale 1ns/100ps
`default_nettype none
module sdram_burst_core
	import sdram_pkg::*;
#(
	parameter int ROW_W = ROW_W_DOC // row address bits, shrink for simulation
) (
	input  wire logic                  I_MCLK,            // clock, 100 MHz
	input  wire logic                  I_RST,             // async reset, high
	input  wire logic                  I_CKE,             // clock enable, low freezes
	input  wire logic                  I_CS_N,            // chip select, low
	input  wire logic                  I_RAS_N,           // row strobe, low
	input  wire logic                  I_CAS_N,           // column strobe, low
	input  wire logic                  I_WE_N,            // write strobe, low
	input  wire logic [MODE_W-1:0]     I_ADDR,            // address lines 0..11
	input  wire logic                  I_UPPER_BYTE_MASK, // masks data bits 15..8
	input  wire logic                  I_LOWER_BYTE_MASK, // masks data bits 7..0
	input  wire logic [DQ_W-1:0]       I_DQ,              // data pins, input side
	output logic      [DQ_W-1:0]       O_DQ,              // data pins, output side
	output logic      [1:0]            O_DQ_OE,           // per byte drive enable
	output logic      [1:0]            O_BANK_ACTIVE      // row open per bank
);
	import sdram_pkg::*;

	typedef struct packed {
		logic [MODE_W-1:0]                 mode;
		logic [1:0]                        bank_act;
		logic [1:0][ROW_W-1:0]             row;
		logic                              is_wr;
		logic [PIPE_DEPTH-1:0]             vld;
		logic [PIPE_DEPTH-1:0][DQ_W-1:0]   dat;
		logic                              ap_pend;
		logic                              ap_bank;
		logic [1:0]                        bm_d1;
		logic [1:0]                        bm_d2;
		logic [DQ_W-1:0]                   dq;
		logic                              oe_raw;
		logic [1:0]                        dq_oe;
	} core_s;

	core_s      s_q, s_d;
	cmd_e       cmd;
	logic       lat3;
	logic       wr_dir;
	logic       out_vld;
	logic       nxt_vld;
	logic [1:0] bmask;

	burst_if        bi ();
	store_if #(ROW_W) st ();

	burst_seq u_seq (
		.I_MCLK (I_MCLK),
		.I_RST  (I_RST),
		.I_CKE  (I_CKE),
		.b      (bi.seq)
	);

	sdram_store #(.ROW_W(ROW_W)) u_store (
		.I_MCLK (I_MCLK),
		.m      (st.mem)
	);

	// command decode and burst control; line 11 is the bank, line 10 the ap flag
	always_comb begin
		cmd       = decode_cmd(I_CS_N, I_RAS_N, I_CAS_N, I_WE_N);
		lat3      = s_q.mode[LAT_LSB +: 3] == LAT_3;              // reserved acts as two
		bmask     = {I_UPPER_BYTE_MASK, I_LOWER_BYTE_MASK};
		bi.start  = cmd == CMD_READ || cmd == CMD_WRITE;
		bi.col_in = I_ADDR[COL_W-1:0];                            // lines 8, 9 unused
		bi.bank_in = I_ADDR[A_BANK];
		bi.ap_in  = I_ADDR[A_AP];
		bi.bl     = s_q.mode[BL_LSB +: 3];
		bi.ilv    = s_q.mode[BT_BIT];
		bi.single = cmd == CMD_WRITE && s_q.mode[WM_LSB +: 3] == WM_SINGLE;
		// a precharge of the bursting bank cuts the burst like a burst stop
		bi.stop   = cmd == CMD_BST ||
			(cmd == CMD_PRE && (I_ADDR[A_AP] || I_ADDR[A_BANK] == bi.bank));
		wr_dir    = cmd == CMD_WRITE ? 1'b1 : (cmd == CMD_READ ? 1'b0 : s_q.is_wr);
	end

	// array port: writes land the cycle the word is on the pins
	always_comb begin
		st.bank  = bi.bank;
		st.row   = s_q.row[bi.bank];
		st.col   = bi.col;
		st.wdata = I_DQ;                                           // zero latency
		st.we    = (I_CKE && bi.valid && wr_dir) ? ~bmask : 2'h0;
	end

	// next state of mode, banks, read pipe and pins
	always_comb begin
		s_d = s_q;
		// auto-precharge starts one edge after the last internal word
		if (s_q.ap_pend)
			s_d.bank_act[s_q.ap_bank] = 1'b0;
		s_d.ap_pend = bi.valid && bi.last && bi.ap;
		s_d.ap_bank = bi.bank;
		case (cmd)
			CMD_MRS: begin
				s_d.mode = I_ADDR;
			end
			CMD_ACT: begin
				s_d.bank_act[I_ADDR[A_BANK]] = 1'b1;
				s_d.row[I_ADDR[A_BANK]]      = I_ADDR[ROW_W-1:0];
			end
			CMD_PRE: begin
				if (I_ADDR[A_AP])
					s_d.bank_act = 2'h0;
				else
					s_d.bank_act[I_ADDR[A_BANK]] = 1'b0;
			end
			default: begin
			end
		endcase
		if (bi.start)
			s_d.is_wr = wr_dir;
		// read pipe: word k enters stage 0 at edge k and leaves at edge k + latency
		s_d.dat[0] = st.rdata;
		s_d.vld[0] = bi.valid && !wr_dir;
		for (int i = 1; i < PIPE_DEPTH; i++) begin
			s_d.dat[i] = s_q.dat[i-1];
			s_d.vld[i] = s_q.vld[i-1];
		end
		out_vld  = lat3 ? s_q.vld[2] : s_q.vld[1];
		nxt_vld  = lat3 ? s_q.vld[1] : s_q.vld[0];
		s_d.dq   = lat3 ? s_q.dat[2] : s_q.dat[1];
		// drivers lead the first word by one cycle and drop after the last one
		s_d.oe_raw = out_vld || nxt_vld;
		// masks only gate the drivers, so the burst keeps counting underneath
		s_d.bm_d1 = bmask;
		s_d.bm_d2 = s_q.bm_d1;
		s_d.dq_oe = {2{s_d.oe_raw}} & ~s_q.bm_d2;
		if (!I_CKE)
			s_d = s_q;
	end

	// state register
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			s_q      <= '0;
			s_q.mode <= MODE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// pins straight from flops
	assign O_DQ          = s_q.dq;
	assign O_DQ_OE       = s_q.dq_oe;
	assign O_BANK_ACTIVE = s_q.bank_act;

	property p_mode_load;
		@(posedge I_MCLK) disable iff (I_RST || !I_CKE)
		cmd == CMD_MRS |=> s_q.mode == $past(I_ADDR);
	endproperty
	a_mode_load: assert property (p_mode_load) else $error("mode not loaded");

	property p_oe_lead_two;
		@(posedge I_MCLK) disable iff (I_RST || !I_CKE)
		cmd == CMD_READ && !lat3 |=> ##1 s_q.oe_raw ##1 (s_q.oe_raw && s_q.dq == $past(st.rdata, 3));
	endproperty
	a_oe_lead_two: assert property (p_oe_lead_two) else $error("latency two timing");

	property p_oe_lead_three;
		@(posedge I_MCLK) disable iff (I_RST || !I_CKE)
		cmd == CMD_READ && lat3 && !s_q.vld[1] && !s_q.vld[0] |=> ##1 !s_q.oe_raw ##1 s_q.oe_raw;
	endproperty
	a_oe_lead_three: assert property (p_oe_lead_three) else $error("latency three lead");

	property p_read_mask;
		@(posedge I_MCLK) disable iff (I_RST || !I_CKE)
		I_UPPER_BYTE_MASK |-> ##3 !O_DQ_OE[1];
	endproperty
	a_read_mask: assert property (p_read_mask) else $error("upper byte not masked");

	property p_write_start;
		@(posedge I_MCLK) disable iff (I_RST || !I_CKE)
		cmd == CMD_WRITE |-> st.col == I_ADDR[7:0] && st.bank == I_ADDR[A_BANK]
			&& st.we == ~bmask;
	endproperty
	a_write_start: assert property (p_write_start) else $error("write start wrong");

	property p_single_write;
		@(posedge I_MCLK) disable iff (I_RST || !I_CKE)
		bi.single |=> bi.start || st.we == 2'h0;
	endproperty
	a_single_write: assert property (p_single_write) else $error("single write ran on");

	property p_burst4_end;
		@(posedge I_MCLK) disable iff (I_RST || !I_CKE)
		cmd == CMD_WRITE && !bi.single && bi.bl == BL_4 ##1 !bi.start [*3]
		|=> bi.start || !bi.valid;
	endproperty
	a_burst4_end: assert property (p_burst4_end) else $error("burst did not end");

	property p_precharge;
		@(posedge I_MCLK) disable iff (I_RST || !I_CKE)
		cmd == CMD_PRE |=> (O_BANK_ACTIVE == 2'h0) ||
			(!$past(I_ADDR[A_AP]) && !O_BANK_ACTIVE[$past(I_ADDR[A_BANK])]);
	endproperty
	a_precharge: assert property (p_precharge) else $error("precharge missed bank");

	property p_auto_pre;
		@(posedge I_MCLK) disable iff (I_RST || !I_CKE)
		bi.valid && bi.last && bi.ap && cmd != CMD_ACT ##1 cmd != CMD_ACT
		|=> !O_BANK_ACTIVE[$past(bi.bank, 2)];
	endproperty
	a_auto_pre: assert property (p_auto_pre) else $error("auto precharge late");
endmodule : sdram_burst_core
`default_nettype wire

// ===== tb/sdram_ctl_model.sv
// controller model that drives commands, masks and write data into the dram
`timescale 1ns/100ps
`default_nettype none
module sdram_ctl_model #(
	parameter int PRECHARGE_WAIT = 2 // idle cycles after a precharge
) (
	input  wire logic        i_clk,   // device clock
	output logic      [3:0]  o_cmd,   // cs, ras, cas, we strobes, low active
	output logic      [11:0] o_addr,  // address lines
	output logic      [1:0]  o_mask,  // upper and lower byte mask
	output logic      [15:0] o_dq,    // write data
	output logic             o_dq_oe  // high while driving write data
);
	localparam logic [3:0] cmd_nop = 4'h7;
	localparam logic [3:0] cmd_pre = 4'h2;
	localparam logic [3:0] cmd_act = 4'h3;
	localparam logic [3:0] cmd_mrs = 4'h0;

	// idle values at time zero
	initial begin
		o_cmd   = cmd_nop;
		o_addr  = 12'h000;
		o_mask  = 2'h0;
		o_dq    = 16'h0000;
		o_dq_oe = 1'b0;
	end

	// one command per cycle, changed just after the falling edge
	task issue(input logic [3:0] c, input logic [11:0] a, input logic [15:0] d,
			input logic [1:0] m, input logic oe);
		@(negedge i_clk);
		o_cmd   = c;
		o_addr  = (c == cmd_nop) ? ~o_addr : a; // unused address keeps moving
		o_dq    = d;
		o_mask  = m;
		o_dq_oe = oe;
	endtask : issue

	// close both banks, load the mode, reopen row 0 of both banks
	task setup(input logic [11:0] mode);
		issue(cmd_nop, 12'h000, 16'h0000, 2'h0, 1'b0); // write recovery
		issue(cmd_pre, 12'h400, 16'h0000, 2'h0, 1'b0); // banks idle first
		repeat (PRECHARGE_WAIT) issue(cmd_nop, 12'h000, 16'h0000, 2'h0, 1'b0);
		issue(cmd_mrs, mode, 16'h0000, 2'h0, 1'b0); // only two or three latency
		repeat (2) issue(cmd_nop, 12'h000, 16'h0000, 2'h0, 1'b0);
		issue(cmd_act, 12'h000, 16'h0000, 2'h0, 1'b0); // open before access
		issue(cmd_act, 12'h800, 16'h0000, 2'h0, 1'b0);
		issue(cmd_nop, 12'h000, 16'h0000, 2'h0, 1'b0);
	endtask : setup
endmodule : sdram_ctl_model
`default_nettype wire

// ===== tb/sdram_mode_and_burst_access_tb_top.sv
// self-checking bench: burst reads and writes against a word-level model
`timescale 1ns/100ps
`default_nettype none
module sdram_mode_and_burst_access_tb_top;
	import sdram_pkg::*;
	localparam int         MAX_CYCLES = 20000; // far above the full sequence
	localparam logic [3:0] cmd_nop    = 4'h7;
	localparam logic [3:0] cmd_rd     = 4'h5;
	localparam logic [3:0] cmd_wr     = 4'h4;
	localparam logic [3:0] cmd_pre    = 4'h2;
	localparam logic [3:0] cmd_bst    = 4'h6;
	logic        I_MCLK;
	logic        I_RST;
	logic        cke;
	logic [3:0]  cmd;
	logic [11:0] addr;
	logic [1:0]  mask;
	logic [15:0] ctl_dq;
	logic        ctl_oe;
	logic [15:0] dq_in;
	logic [15:0] dq_out;
	logic [1:0]  dq_oe;
	logic [1:0]  bank_act;
	int          bad_count = 0;
	int          checks = 0;
	int          cycles = 0;
	int          seed = 32'h1e632a8a;
	int          cur_len, cur_lat;
	bit          cur_ilv, cur_single;
	logic [15:0] mem [int];

	// released bus never shows the stale value
	assign dq_in = ctl_oe ? ctl_dq : ~dq_out;

	sdram_burst_core #(.ROW_W(2)) sdram_burst_core_inst (
		.I_MCLK(I_MCLK), .I_RST(I_RST), .I_CKE(cke), .I_CS_N(cmd[3]), .I_RAS_N(cmd[2]),
		.I_CAS_N(cmd[1]), .I_WE_N(cmd[0]), .I_ADDR(addr), .I_UPPER_BYTE_MASK(mask[1]),
		.I_LOWER_BYTE_MASK(mask[0]), .I_DQ(dq_in), .O_DQ(dq_out), .O_DQ_OE(dq_oe),
		.O_BANK_ACTIVE(bank_act));
	sdram_ctl_model sdram_ctl_model_inst (.i_clk(I_MCLK), .o_cmd(cmd), .o_addr(addr),
		.o_mask(mask), .o_dq(ctl_dq), .o_dq_oe(ctl_oe));

	// 100 MHz clock
	initial I_MCLK = 1'b0;
	always #5 I_MCLK = ~I_MCLK;

	// a hang counts as a mismatch
	always @(posedge I_MCLK) begin
		cycles = cycles + 1;
		if (cycles == MAX_CYCLES) begin
			bad_count++;
			summarize();
		end
	end

	task summarize();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// column of transfer k, worked out with integers
	function automatic int seq_col(int s, int k, int len, bit ilv);
		if (len == 256)
			return (s + k) % 256;
		return (s - s % len) + (ilv ? ((s % len) ^ k) : ((s % len + k) % len));
	endfunction : seq_col

	task setup(input logic [2:0] bl, input bit ilv, input logic [2:0] lat, input logic [2:0] wm);
		cur_len    = (bl == BL_FULL) ? 256 : (1 << bl);
		cur_lat    = (lat == LAT_3) ? 3 : 2;
		cur_ilv    = ilv;
		cur_single = (wm == WM_SINGLE);
		sdram_ctl_model_inst.setup({wm, 2'b00, lat, ilv, bl});
		chk({14'h0, bank_act}, 16'h0003);
	endtask : setup

	// n + 1 words offered; the word after the burst must be ignored
	task wr(input int bank, input int col, input int n, input bit stop, input bit fill);
		int k, c, lim;
		logic [15:0] d;
		logic [1:0] m;
		logic [3:0] op;
		lim = cur_single ? 1 : (cur_len == 256 ? n : cur_len);
		for (k = 0; k <= n; k++) begin
			d = 16'($random(seed));
			m = fill ? 2'b00 : 2'($random(seed));
			op = (k == 0) ? cmd_wr : ((k == n && stop) ? cmd_bst : cmd_nop);
			sdram_ctl_model_inst.issue(op, {1'(bank), 1'b0, 2'($random(seed)), 8'(col)}, d, m, 1'b1);
			if (k < n && k < lim) begin
				c = bank * 256 + seq_col(col, k, cur_len, cur_ilv);
				mem[c] = {m[1] ? mem[c][15:8] : d[15:8], m[0] ? mem[c][7:0] : d[7:0]};
			end
		end
		sdram_ctl_model_inst.issue(cmd_nop, 12'h000, 16'h0000, 2'b00, 1'b0);
	endtask : wr

	// read, optional stop edge for full page and one upper mask edge
	task rd(input int bank, input int col, input bit ap, input int stop_at, input int mat);
		int j, nw;
		logic [1:0] m;
		logic [3:0] op;
		nw = (cur_len == 256) ? stop_at : cur_len;
		sdram_ctl_model_inst.issue(cmd_rd, {1'(bank), ap, 2'($random(seed)), 8'(col)},
			16'h0000, 2'b00, 1'b0);
		for (j = 0; j <= cur_lat + nw; j++) begin
			op = (cur_len == 256 && j + 1 == stop_at) ? cmd_bst : cmd_nop;
			m = (j + 1 == mat) ? 2'b10 : 2'b00;
			sdram_ctl_model_inst.issue(op, 12'h000, 16'h0000, m, 1'b0);
			if (j == cur_lat - 1)
				chk({14'h0, dq_oe}, 16'h0003);
			if (j >= cur_lat && j < cur_lat + nw && j != mat + 2)
				chk(dq_out, mem[bank * 256 + seq_col(col, j - cur_lat, cur_len, cur_ilv)]);
			if (j == mat + 2 && j < cur_lat + nw)
				chk({14'h0, dq_oe}, 16'h0001);
			if (ap && cur_len < 256 && (j == nw - 1 || j == nw))
				chk({15'h0, bank_act[bank]}, {15'h0, 1'(j == nw - 1)});
		end
		chk({14'h0, dq_oe}, 16'h0000);
		if (ap && cur_len == 256)
			chk({15'h0, bank_act[bank]}, 16'h0001);
	endtask : rd

	// main sequence
	initial begin
		int lat, ilv, bl, b, c;
		I_RST = 1'b1;
		cke   = 1'b1;
		repeat (3) @(negedge I_MCLK);
		I_RST = 1'b0;
		chk({12'h0, dq_oe, bank_act}, 16'h0000);
		// fill both banks with a wrapping full page write
		setup(BL_FULL, 1'b0, LAT_2, WM_BURST);
		wr(0, 0, 260, 1'b1, 1'b1);
		wr(1, 0, 260, 1'b1, 1'b1);
		rd(1, 250, 1'b1, 10, -5);
		// every fixed length, order and latency, with random masks and columns
		for (lat = 0; lat < 2; lat++) begin
			for (ilv = 0; ilv < 2; ilv++) begin
				for (bl = 0; bl < 4; bl++) begin
					setup(3'(bl), 1'(ilv), lat ? LAT_3 : LAT_2, WM_BURST);
					b = $random(seed) & 1;
					c = $random(seed) & 8'hff;
					wr(b, c, cur_len + 1, 1'b0, 1'b0);
					rd(b, c ^ 3, 1'b0, 0, cur_lat + 1);
				end
			end
		end
		// auto-precharge timing at both latencies
		for (lat = 0; lat < 2; lat++) begin
			setup(BL_4, 1'b0, lat ? LAT_3 : LAT_2, WM_BURST);
			rd(0, 5, 1'b1, 0, -5);
		end
		// single write mode stores only the addressed column
		setup(BL_4, 1'b1, LAT_3, WM_SINGLE);
		wr(1, 12, 5, 1'b0, 1'b0);
		rd(1, 12, 1'b0, 0, -5);
		// one bank, then both banks precharged
		setup(BL_1, 1'b0, LAT_2, WM_BURST);
		// clock enable low: a precharge of both banks must be ignored
		@(negedge I_MCLK);
		cke = 1'b0;
		sdram_ctl_model_inst.issue(cmd_pre, 12'h400, 16'h0000, 2'b00, 1'b0);
		sdram_ctl_model_inst.issue(cmd_nop, 12'h000, 16'h0000, 2'b00, 1'b0);
		chk({14'h0, bank_act}, 16'h0003);
		cke = 1'b1;
		sdram_ctl_model_inst.issue(cmd_pre, 12'h800, 16'h0000, 2'b00, 1'b0);
		sdram_ctl_model_inst.issue(cmd_nop, 12'h000, 16'h0000, 2'b00, 1'b0);
		chk({14'h0, bank_act}, 16'h0001);
		sdram_ctl_model_inst.issue(cmd_pre, 12'h400, 16'h0000, 2'b00, 1'b0);
		sdram_ctl_model_inst.issue(cmd_nop, 12'h000, 16'h0000, 2'b00, 1'b0);
		chk({14'h0, bank_act}, 16'h0000);
		summarize();
	end
endmodule : sdram_mode_and_burst_access_tb_top
`default_nettype wire
